// *** rtl/bas_pkg.sv ***
// package: register map, field layout, reset values and opcodes of the byte alu
package bas_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_WORK   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_FPTR   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_FDATA  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h14;

	// command word fields
	localparam int unsigned CTRL_OP_LSB   = 0;
	localparam int unsigned CTRL_OP_W     = 2;
	localparam int unsigned CTRL_DEST_BIT = 2;
	localparam int unsigned CTRL_FA_LSB   = 8;
	localparam int unsigned FA_W          = 7;
	localparam int unsigned CTRL_LIT_LSB  = 16;

	// status fields
	localparam int unsigned ST_CARRY_BIT = 0;
	localparam int unsigned ST_DC_BIT    = 1;
	localparam int unsigned ST_ZERO_BIT  = 2;

	localparam int unsigned FILE_DEPTH = 128;

	localparam logic [7:0]        WORK_RST   = 8'h00;
	localparam logic [7:0]        FILE_RST   = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [FA_W-1:0]   FPTR_RST   = 7'h00;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// encodings of the op field
	typedef enum logic [1:0]
	{
		OP_SUB_WORK_FROM_FILE,
		OP_NIBBLE_SWAP_FILE,
		OP_XOR_WORK_WITH_FILE,
		OP_XOR_LITERAL_WITH_WORK
	} bas_op_t;

endpackage

// *** rtl/bas_byte_alu.sv ***
// byte alu slice with a 128-entry file, working register and axi4-lite access
// Notes on behaviour
// RULE1 - subtract: file minus work, dest picks target
// RULE2 - carry and digit carry mean no borrow
// RULE3 - swap file nibbles, dest picks target, flags kept
// RULE4 - xor work with file, dest picks target
// RULE5 - decode 7-bit file address and dest bit
// RULE6 - xor work with literal, always into work
// RULE7 - zero flag set when result is zero
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

module bas_byte_alu
	import bas_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [bas_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	input  wire logic [bas_pkg::DATA_W-1:0] s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	output logic [1:0]                 s_axi_bresp_o,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	input  wire logic [bas_pkg::ADDR_W-1:0] s_axi_araddr_i,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	output logic [bas_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       carry_o,
	output logic                       digit_carry_o,
	output logic                       zero_o
);
	import bas_pkg::*;

	// byte-lane merge of a write into an old register image
	function automatic logic [DATA_W-1:0] merge_strb
	(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0]        strb
	);
		logic [DATA_W-1:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				m[8*i +: 8] = new_v[8*i +: 8];
		end
		return m;
	endfunction

	function automatic logic is_zero(input logic [7:0] v);
		return (v == 8'h00);
	endfunction

	// write channel state
	logic                  aw_held_ff;
	logic [ADDR_W-1:0]     aw_addr_ff;
	logic                  w_held_ff;
	logic [DATA_W-1:0]     w_data_ff;
	logic [3:0]            w_strb_ff;
	logic                  awready_ff;
	logic                  wready_ff;
	logic                  bvalid_ff;
	logic [1:0]            bresp_ff;
	// read channel state
	logic                  arready_ff;
	logic                  rvalid_ff;
	logic [DATA_W-1:0]     rdata_ff;
	logic [1:0]            rresp_ff;
	// block state
	logic [DATA_W-1:0]     ctrl_ff;
	logic [7:0]            work_ff;
	logic [7:0]            result_ff;
	logic [FA_W-1:0]       fptr_ff;
	logic                  carry_ff;
	logic                  dc_ff;
	logic                  zero_ff;
	logic [7:0]            file_ff [FILE_DEPTH];

	wire logic aw_take  = s_axi_awvalid_i & awready_ff;
	wire logic w_take   = s_axi_wvalid_i & wready_ff;
	wire logic ar_take  = s_axi_arvalid_i & arready_ff;
	wire logic do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

	wire logic nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
	wire logic nxt_w_held  = (w_held_ff | w_take) & ~do_write;
	wire logic nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready_i);
	wire logic nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready_i);

	// write address decode
	wire logic wr_ctrl   = do_write & (aw_addr_ff == OFF_CTRL);
	wire logic wr_work   = do_write & (aw_addr_ff == OFF_WORK);
	wire logic wr_status = do_write & (aw_addr_ff == OFF_STATUS);
	wire logic wr_fptr   = do_write & (aw_addr_ff == OFF_FPTR);
	wire logic wr_fdata  = do_write & (aw_addr_ff == OFF_FDATA);
	wire logic wr_result = aw_addr_ff == OFF_RESULT;
	wire logic wr_mapped = wr_ctrl | wr_work | wr_status | wr_fptr | wr_fdata
		| (do_write & wr_result);

	// a command write runs the instruction it carries in the same cycle
	wire logic [DATA_W-1:0] nxt_ctrl = merge_strb(ctrl_ff, w_data_ff, w_strb_ff);
	wire logic [DATA_W-1:0] nxt_misc = merge_strb('0, w_data_ff, w_strb_ff);

	wire bas_op_t         op_sel  = bas_op_t'(nxt_ctrl[CTRL_OP_LSB +: CTRL_OP_W]);
	wire logic            dest_f  = nxt_ctrl[CTRL_DEST_BIT]; // [RULE5]
	wire logic [FA_W-1:0] fa_sel  = nxt_ctrl[CTRL_FA_LSB +: FA_W]; // [RULE5]
	wire logic [7:0]      lit_sel = nxt_ctrl[CTRL_LIT_LSB +: 8];
	wire logic [7:0]      f_val   = file_ff[fa_sel];

	wire logic [7:0] diff_v = f_val - work_ff; // [RULE1]
	wire logic       c_sub  = work_ff <= f_val; // [RULE2]
	wire logic       dc_sub = work_ff[3:0] <= f_val[3:0]; // [RULE2]
	wire logic [7:0] swap_v = {f_val[3:0], f_val[7:4]}; // [RULE3]
	wire logic [7:0] xwf_v  = work_ff ^ f_val; // [RULE4]
	wire logic [7:0] xlw_v  = work_ff ^ lit_sel; // [RULE6]

	logic [7:0] alu_res;
	logic       to_file;
	logic       upd_cdc;
	logic       upd_z;

	always_comb
	begin
		alu_res = diff_v;
		to_file = dest_f;
		upd_cdc = 1'b0;
		upd_z   = 1'b0;
		case (op_sel)
			OP_SUB_WORK_FROM_FILE:
			begin
				alu_res = diff_v; // [RULE1]
				upd_cdc = 1'b1; // [RULE2]
				upd_z   = 1'b1; // [RULE7]
			end
			OP_NIBBLE_SWAP_FILE:
			begin
				alu_res = swap_v; // [RULE3]
			end
			OP_XOR_WORK_WITH_FILE:
			begin
				alu_res = xwf_v; // [RULE4]
				upd_z   = 1'b1; // [RULE4]
			end
			OP_XOR_LITERAL_WITH_WORK:
			begin
				alu_res = xlw_v; // [RULE6]
				to_file = 1'b0; // [RULE6]
				upd_z   = 1'b1; // [RULE6]
			end
			default:
			begin
				alu_res = diff_v;
			end
		endcase
	end

	wire logic exec      = wr_ctrl;
	wire logic exec_file = exec & to_file; // [RULE1] [RULE3] [RULE4]
	wire logic exec_work = exec & ~to_file; // [RULE1] [RULE3] [RULE4] [RULE6]

	// read address decode
	logic [DATA_W-1:0] rd_word;
	logic              rd_hit;

	always_comb
	begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (s_axi_araddr_i)
			OFF_CTRL:   rd_word = ctrl_ff;
			OFF_WORK:   rd_word = {24'h00_0000, work_ff};
			OFF_STATUS:
			begin
				rd_word[ST_CARRY_BIT] = carry_ff;
				rd_word[ST_DC_BIT]    = dc_ff;
				rd_word[ST_ZERO_BIT]  = zero_ff;
			end
			OFF_FPTR:   rd_word = {25'h000_0000, fptr_ff};
			OFF_FDATA:  rd_word = {24'h00_0000, file_ff[fptr_ff]};
			OFF_RESULT: rd_word = {24'h00_0000, result_ff};
			default:    rd_hit  = 1'b0;
		endcase
	end

	// bus handshake registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff  <= 1'b0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end
		else
		begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			if (aw_take)
				aw_addr_ff <= s_axi_awaddr_i;
			if (w_take)
			begin
				w_data_ff <= s_axi_wdata_i;
				w_strb_ff <= s_axi_wstrb_i;
			end
			// ready only while the slot is empty and no answer is pending
			awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			if (do_write)
				bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end
		else
		begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take)
			begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// working register, flags, command image and result
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_ff   <= CTRL_RST;
			work_ff   <= WORK_RST;
			result_ff <= WORK_RST;
			fptr_ff   <= FPTR_RST;
			carry_ff  <= 1'b0;
			dc_ff     <= 1'b0;
			zero_ff   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_ff   <= nxt_ctrl;
				result_ff <= alu_res;
			end
			if (exec_work)
				work_ff <= alu_res;
			else if (wr_work)
				work_ff <= nxt_misc[7:0];
			if (wr_fptr)
				fptr_ff <= nxt_misc[FA_W-1:0];
			if (exec & upd_cdc)
			begin
				carry_ff <= c_sub; // [RULE2]
				dc_ff    <= dc_sub; // [RULE2]
			end
			else if (wr_status)
			begin
				carry_ff <= nxt_misc[ST_CARRY_BIT];
				dc_ff    <= nxt_misc[ST_DC_BIT];
			end
			if (exec & upd_z)
				zero_ff <= is_zero(alu_res); // [RULE7]
			else if (wr_status)
				zero_ff <= nxt_misc[ST_ZERO_BIT];
		end
	end

	// file storage; a command and a direct data write never share a cycle
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < FILE_DEPTH; i++)
				file_ff[i] <= FILE_RST;
		end
		else
		begin
			if (exec_file)
				file_ff[fa_sel] <= alu_res;
			else if (wr_fdata & w_strb_ff[0])
				file_ff[fptr_ff] <= w_data_ff[7:0];
		end
	end

	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o  = wready_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rdata_o   = rdata_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign carry_o         = carry_ff;
	assign digit_carry_o   = dc_ff;
	assign zero_o          = zero_ff;

endmodule // bas_byte_alu

// *** testbench/bas_byte_alu_sva.sv ***
// checker: bus timing and flag update relations of the byte alu
`timescale 1ns/100ps
module bas_byte_alu_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        carry_o,
	input wire logic        digit_carry_o,
	input wire logic        zero_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// flags only move on the edge a write commits
	property p_flags_on_write;
		$changed({carry_o, digit_carry_o, zero_o}) |-> $rose(s_axi_bvalid_o);
	endproperty
	a_flags_on_write: assert property (p_flags_on_write) else $error("flags moved alone");
	property p_write_lat;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
			|=> !s_axi_bvalid_o ##1 s_axi_bvalid_o;
	endproperty
	a_write_lat: assert property (p_write_lat) else $error("write answer late");
	property p_read_unmapped;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h14
			|=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read");
	property p_byte_wide;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i != 8'h00
			|=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h0;
	endproperty
	a_byte_wide: assert property (p_byte_wide) else $error("read answer wrong");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("response dropped");
	property p_no_overlap;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("ready while busy");
	property p_ready_back;
		$fell(s_axi_rvalid_o) |-> s_axi_arready_o;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("arready late");
	c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
	c_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10);
	c_zero: cover property ($rose(zero_o));
endmodule // bas_byte_alu_chk
bind bas_byte_alu bas_byte_alu_chk u_chk (
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.s_axi_awvalid_i (s_axi_awvalid_i),
	.s_axi_awready_o (s_axi_awready_o),
	.s_axi_wvalid_i  (s_axi_wvalid_i),
	.s_axi_wready_o  (s_axi_wready_o),
	.s_axi_bvalid_o  (s_axi_bvalid_o),
	.s_axi_bready_i  (s_axi_bready_i),
	.s_axi_bresp_o   (s_axi_bresp_o),
	.s_axi_arvalid_i (s_axi_arvalid_i),
	.s_axi_arready_o (s_axi_arready_o),
	.s_axi_araddr_i  (s_axi_araddr_i),
	.s_axi_rvalid_o  (s_axi_rvalid_o),
	.s_axi_rready_i  (s_axi_rready_i),
	.s_axi_rdata_o   (s_axi_rdata_o),
	.s_axi_rresp_o   (s_axi_rresp_o),
	.carry_o         (carry_o),
	.digit_carry_o   (digit_carry_o),
	.zero_o          (zero_o)
);

// *** testbench/byte_alu_sub_swap_xor_tb_top.sv ***
// testbench: bus master, result queue and alu reference for the byte alu
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module byte_alu_sub_swap_xor_tb_top;
	import bas_pkg::*;
	logic        clk_i = 0, rst_i = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rd_d;
	logic [3:0]  ws = 4'hf;
	logic        awr, wrd, bv, arr, rv, c, dc, z;
	logic [1:0]  br, rr;
	logic [33:0] q[$];
	int          n_fail = 0, num_checks = 0;
	initial forever #2.5 clk_i = ~clk_i;
	bas_byte_alu dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(brdy), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rrdy), .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rr),
		.carry_o(c), .digit_carry_o(dc), .zero_o(z));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// an answer with no note queued is compared against its own inverse
	task automatic cmp(input logic [33:0] got);
		logic [33:0] e;
		e = q.size() ? q.pop_front() : ~got;
		`CHK(got, e)
	endtask
	always @(negedge clk_i)
	begin
		if (bv && brdy)
			cmp({br, 32'h0});
		if (rv && rrdy)
			cmp({rr, rd_d});
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit ta, tw;
		q.push_back({r, 32'h0});
		@(posedge clk_i);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		do
		begin
			@(negedge clk_i);
			ta = awv && awr;
			tw = wv && wrd;
			@(posedge clk_i);
			if (ta)
				awv <= 0;
			if (tw)
				wv <= 0;
		end while ((awv && !ta) || (wv && !tw));
		repeat ($urandom % 3) @(posedge clk_i);
		brdy <= 1;
		do @(negedge clk_i); while (!bv);
		@(posedge clk_i);
		brdy <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		q.push_back({r, d});
		@(posedge clk_i);
		ara <= a;
		arv <= 1;
		do @(negedge clk_i); while (!arr);
		@(posedge clk_i);
		arv <= 0;
		repeat ($urandom % 3) @(posedge clk_i);
		rrdy <= 1;
		do @(negedge clk_i); while (!rv);
		@(posedge clk_i);
		rrdy <= 0;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		report_and_stop;
	end
	initial
	begin
		logic [7:0] w, f, k, res;
		logic [31:0] cmd;
		logic [6:0] fa;
		logic [2:0] fl;
		logic       dst, to_f;
		int         op;
		void'($urandom(32'h0b1abf36));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rd(OFF_WORK, 0, RESP_OKAY);
		rd(OFF_STATUS, 0, RESP_OKAY);
		wr(OFF_RESULT, 32'h5a, RESP_OKAY);
		rd(OFF_RESULT, 0, RESP_OKAY);
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, 0, RESP_SLVERR);
		$display("test reset_and_map done");
		for (int i = 0; i < 40; i++)
		begin
			op = i % 4;
			w = 8'($urandom);
			f = ($urandom % 4) ? 8'($urandom) : w;
			k = ($urandom % 4) ? 8'($urandom) : w;
			fa = (i < 4) ? 7'h7f : (i < 8) ? 7'h00 : 7'($urandom);
			dst = 1'($urandom);
			fl = 3'($urandom);
			wr(OFF_FPTR, fa, RESP_OKAY);
			wr(OFF_FDATA, f, RESP_OKAY);
			wr(OFF_WORK, w, RESP_OKAY);
			wr(OFF_STATUS, fl, RESP_OKAY);
			to_f = dst && op != 3;
			case (op)
				0: begin res = f - w; fl = {res == 0, w[3:0] <= f[3:0], w <= f}; end
				1: res = {f[3:0], f[7:4]};
				2: begin res = w ^ f; fl[2] = res == 0; end
				default: begin res = w ^ k; fl[2] = res == 0; end
			endcase
			cmd = {8'h00, k, 1'b0, fa, 5'h00, dst, op[1:0]};
			wr(OFF_CTRL, cmd, RESP_OKAY);
			`CHK({z, dc, c}, fl)
			rd(OFF_RESULT, res, RESP_OKAY);
			rd(OFF_WORK, to_f ? w : res, RESP_OKAY);
			rd(OFF_FDATA, to_f ? res : f, RESP_OKAY);
			rd(OFF_FPTR, fa, RESP_OKAY);
			rd(OFF_STATUS, fl, RESP_OKAY);
			rd(OFF_CTRL, cmd, RESP_OKAY);
		end
		$display("test alu_ops done");
		report_and_stop;
	end
endmodule // byte_alu_sub_swap_xor_tb_top
